/* File: design/tic_top.sv */
// Trigger input conditioning top: sync, debounce, source select, registers.
// Assumes an Avalon-MM master on sys_clk and asynchronous input pins.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module tic_top #(
    parameter int MAIN_N  = tic_pkg::MAIN_INPUTS,
    parameter int FRONT_N = tic_pkg::FRONT_INPUTS
) (
    input  wire logic                       sys_clk,
    input  wire logic                       reset,
    input  wire logic [MAIN_N-1:0]          main_input_pins,
    input  wire logic [FRONT_N-1:0]         front_input_pins,
    input  wire logic [tic_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    output logic                            ext_trigger_out,
    output logic                            stat_source_out
);

    localparam int ALL_N = MAIN_N + FRONT_N;

    // =======================================================================
    // Input synchronisation
    logic [ALL_N-1:0] raw_all;
    logic [ALL_N-1:0] sync_all;
    logic [ALL_N-1:0] stable_all;

    assign raw_all = {front_input_pins, main_input_pins};

    tic_sync #(
        .N         (ALL_N)
    ) u_sync (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .raw_in    (raw_all),
        .level_out (sync_all)
    );

    // =======================================================================
    // Configuration state
    logic [tic_pkg::TIME_W-1:0] time_steps_q, time_steps_d;
    logic [tic_pkg::CNT_W-1:0]  limit_cyc_q, limit_cyc_d;
    logic [tic_pkg::SEL_W-1:0]  source_sel_q, source_sel_d;
    logic [1:0]                 mode_q, mode_d;
    logic                       polarity_q, polarity_d;

    // =======================================================================
    // Debounce, one shared limit
    tic_debounce #(
        .N          (ALL_N),
        .CNT_W      (tic_pkg::CNT_W)
    ) u_debounce (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .level_in   (sync_all),
        .limit_cyc  (limit_cyc_q), // RQ4
        .stable_out (stable_all)
    );

    // =======================================================================
    // Bus handshake state
    tic_pkg::tic_bus_state_t bus_state_q, bus_state_d;
    logic [31:0]             rdata_q, rdata_d;
    logic                    wait_q, wait_d;
    logic                    commit_wr;
    logic [31:0]             rd_mux;

    assign commit_wr = (bus_state_q == tic_pkg::BUS_ACK) && avs_write;

    always_comb begin
        rd_mux = '0;
        case (avs_address)
            tic_pkg::OFS_MAIN_LEVELS: begin
                rd_mux[MAIN_N-1:0] = sync_all[MAIN_N-1:0]; // RQ5
            end
            tic_pkg::OFS_FRONT_LEVELS: begin
                rd_mux[FRONT_N-1:0] = sync_all[ALL_N-1:MAIN_N]; // RQ6
            end
            tic_pkg::OFS_STAB_TIME: begin
                rd_mux[tic_pkg::TIME_W-1:0] = time_steps_q;
            end
            tic_pkg::OFS_CONTROL: begin
                rd_mux[tic_pkg::CTL_SEL_LSB +: tic_pkg::SEL_W] = source_sel_q;
                rd_mux[tic_pkg::CTL_MODE_LSB +: 2]             = mode_q;
                rd_mux[tic_pkg::CTL_POL_BIT]                   = polarity_q;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    always_comb begin
        bus_state_d = bus_state_q;
        rdata_d     = rdata_q;
        wait_d      = wait_q;
        unique case (bus_state_q)
            tic_pkg::BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_state_d = tic_pkg::BUS_ACK;
                    wait_d      = 1'b0;
                    rdata_d     = avs_read ? rd_mux : 32'h0000_0000;
                end
            end
            tic_pkg::BUS_ACK: begin
                bus_state_d = tic_pkg::BUS_IDLE;
                wait_d      = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bus_state_q <= tic_pkg::BUS_IDLE;
            rdata_q     <= 32'h0000_0000;
            wait_q      <= 1'b1;
        end else begin
            bus_state_q <= bus_state_d;
            rdata_q     <= rdata_d;
            wait_q      <= wait_d;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

    // =======================================================================
    // Register writes
    logic [31:0] steps_wide;
    logic [31:0] limit_wide;
    logic [15:0] wr_low;
    logic [15:0] ctl_old;
    logic [15:0] ctl_new;
    logic [tic_pkg::SEL_W-1:0] sel_new;
    logic [1:0]  mode_new;

    always_comb begin
        time_steps_d = time_steps_q;
        limit_cyc_d  = limit_cyc_q;
        source_sel_d = source_sel_q;
        mode_d       = mode_q;
        polarity_d   = polarity_q;
        ctl_old      = '0;
        ctl_old[tic_pkg::CTL_SEL_LSB +: tic_pkg::SEL_W] = source_sel_q;
        ctl_old[tic_pkg::CTL_MODE_LSB +: 2]             = mode_q;
        ctl_old[tic_pkg::CTL_POL_BIT]                   = polarity_q;
        wr_low[7:0]  = avs_byteenable[0] ? avs_writedata[7:0]
                                         : time_steps_q[7:0];
        wr_low[15:8] = avs_byteenable[1] ? avs_writedata[15:8]
                                         : time_steps_q[15:8];
        ctl_new[7:0]  = avs_byteenable[0] ? avs_writedata[7:0]
                                          : ctl_old[7:0];
        ctl_new[15:8] = avs_byteenable[1] ? avs_writedata[15:8]
                                          : ctl_old[15:8];
        sel_new    = ctl_new[tic_pkg::CTL_SEL_LSB +: tic_pkg::SEL_W];
        mode_new   = ctl_new[tic_pkg::CTL_MODE_LSB +: 2];
        steps_wide = {16'h0000, wr_low};
        limit_wide = (steps_wide * 32'(tic_pkg::STEP_PS)
                      + 32'(tic_pkg::CLK_PERIOD_PS - 1))
                     / 32'(tic_pkg::CLK_PERIOD_PS);
        if (commit_wr && avs_address == tic_pkg::OFS_STAB_TIME) begin
            time_steps_d = wr_low; // RQ2
            limit_cyc_d  = limit_wide[tic_pkg::CNT_W-1:0]; // RQ2
        end
        if (commit_wr && avs_address == tic_pkg::OFS_CONTROL) begin
            if (sel_new <= tic_pkg::SOURCE_LAST) begin
                source_sel_d = sel_new; // RQ7
            end
            if (mode_new == tic_pkg::MODE_GENERATOR ||
                mode_new == tic_pkg::MODE_EXTERNAL  ||
                mode_new == tic_pkg::MODE_SOFTWARE) begin
                mode_d = mode_new;
            end
            polarity_d = ctl_new[tic_pkg::CTL_POL_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            time_steps_q <= tic_pkg::DEFAULT_TIME_STEPS; // RQ2
            limit_cyc_q  <= tic_pkg::DEFAULT_LIMIT_CYC; // RQ2
            source_sel_q <= tic_pkg::SOURCE_MAIN_INPUT_0; // RQ7
            mode_q       <= tic_pkg::MODE_GENERATOR;
            polarity_q   <= tic_pkg::POL_HIGH_ACTIVE;
        end else begin
            time_steps_q <= time_steps_d;
            limit_cyc_q  <= limit_cyc_d;
            source_sel_q <= source_sel_d;
            mode_q       <= mode_d;
            polarity_q   <= polarity_d;
        end
    end

    // =======================================================================
    // Source selection and routing
    logic selected_lvl;
    logic polar_lvl;
    logic ext_trig_q, ext_trig_d;
    logic stat_q, stat_d;

    always_comb begin
        selected_lvl = 1'b0;
        for (int i = 0; i < ALL_N; i++) begin
            if (source_sel_q == tic_pkg::SEL_W'(i)) begin
                selected_lvl = stable_all[i]; // RQ7
            end
        end
        polar_lvl = (polarity_q == tic_pkg::POL_LOW_ACTIVE) ? ~selected_lvl
                                                            : selected_lvl;
        stat_d = polar_lvl; // RQ10 RQ8
        if (mode_q == tic_pkg::MODE_EXTERNAL) begin
            ext_trig_d = polar_lvl; // RQ9
        end else begin
            ext_trig_d = 1'b0; // RQ8 RQ9
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ext_trig_q <= 1'b0;
            stat_q     <= 1'b0;
        end else begin
            ext_trig_q <= ext_trig_d;
            stat_q     <= stat_d;
        end
    end

    assign ext_trigger_out = ext_trig_q;
    assign stat_source_out = stat_q;

endmodule : tic_top

/* File: design/tic_pkg.sv */
// Constants shared by the trigger input conditioning block.
// Assumes one 250 MHz clock and an Avalon-MM register slave.
// ===========================================================================
// What this block does
// (RQ1) Accept level only after stable debounce time
// (RQ2) Debounce time 0 to 209.712 us, 0.0032 steps
// (RQ3) Debounced edge lags raw edge by debounce
// (RQ4) One debounce setting for all twelve inputs
// (RQ5) Read main input levels, bits 0 to 7
// (RQ6) Read front input levels, bits 0 to 3
// (RQ7) Select one of twelve inputs, default main 0
// (RQ8) Non-external mode: selector feeds statistics only
// (RQ9) External uses selected input; generator ignores inputs
// (RQ10) Statistics after debounce and polarity, pre-downscale
// (RQ11) Per-input counter restarts on agreement, accepts at limit
// (RQ12) Synchronise every raw input before use
package tic_pkg;

    // =======================================================================
    // Input banks
    localparam int MAIN_INPUTS  = 8;
    localparam int FRONT_INPUTS = 4;
    localparam int ALL_INPUTS   = MAIN_INPUTS + FRONT_INPUTS;
    localparam int SEL_W        = 4;

    // =======================================================================
    // Timing
    localparam int CLK_PERIOD_PS    = 4000;
    localparam int STEP_PS          = 3200;
    localparam int TIME_MAX_STEPS   = 65535;
    localparam int DEFAULT_TIME_PS  = 1000000;
    localparam int TIME_W           = 16;
    localparam int CNT_W            = 16;
    localparam logic [CNT_W-1:0] DEFAULT_LIMIT_CYC =
        CNT_W'((DEFAULT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [TIME_W-1:0] DEFAULT_TIME_STEPS =
        TIME_W'((DEFAULT_TIME_PS + STEP_PS - 1) / STEP_PS);

    // =======================================================================
    // Register map, byte addresses
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_MAIN_LEVELS  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_FRONT_LEVELS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STAB_TIME    = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CONTROL      = 4'hC;

    // Control register fields
    localparam int CTL_SEL_LSB  = 0;
    localparam int CTL_MODE_LSB = 4;
    localparam int CTL_POL_BIT  = 8;

    // =======================================================================
    // Trigger operating modes
    localparam logic [1:0] MODE_GENERATOR = 2'h0;
    localparam logic [1:0] MODE_EXTERNAL  = 2'h1;
    localparam logic [1:0] MODE_SOFTWARE  = 2'h2;

    // Source selector codes
    localparam logic [SEL_W-1:0] SOURCE_MAIN_INPUT_0  = 4'h0;
    localparam logic [SEL_W-1:0] SOURCE_FRONT_INPUT_0 = 4'h8;
    localparam logic [SEL_W-1:0] SOURCE_LAST          = 4'hB;

    // Polarity
    localparam logic POL_HIGH_ACTIVE = 1'b0;
    localparam logic POL_LOW_ACTIVE  = 1'b1;

    // Bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } tic_bus_state_t;

endpackage : tic_pkg

/* File: design/tic_sync.sv */
// Three-stage synchroniser for a bank of raw pin inputs.
// Assumes inputs asynchronous to sys_clk.
`timescale 1ns/1ps
module tic_sync #(
    parameter int N = 12
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic [N-1:0] raw_in,
    output logic      [N-1:0] level_out
);

    // =======================================================================
    // Stages
    logic [N-1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [N-1:0] lvl_d;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            lvl_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : lvl_q[i];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q  <= raw_in; // RQ12
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;

endmodule : tic_sync

/* File: design/tic_debounce.sv */
// Per-input stability filter with one shared limit.
// Assumes synchronised inputs and a limit in clock cycles.
`timescale 1ns/1ps
module tic_debounce #(
    parameter int N     = 12,
    parameter int CNT_W = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [N-1:0]     level_in,
    input  wire logic [CNT_W-1:0] limit_cyc,
    output logic      [N-1:0]     stable_out
);

    // =======================================================================
    // One counter per input
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            logic [CNT_W-1:0] cnt_q, cnt_d;
            logic [CNT_W:0]   next_cnt;
            logic             acc_q, acc_d;

            always_comb begin
                next_cnt = {1'b0, cnt_q} + {{CNT_W{1'b0}}, 1'b1};
                cnt_d    = cnt_q;
                acc_d    = acc_q;
                if (level_in[g] == acc_q) begin
                    cnt_d = '0; // RQ11
                end else if (next_cnt >= {1'b0, limit_cyc}) begin
                    acc_d = level_in[g]; // RQ1 RQ3
                    cnt_d = '0;
                end else begin
                    cnt_d = next_cnt[CNT_W-1:0]; // RQ11
                end
            end

            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    cnt_q <= '0;
                    acc_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_d;
                    acc_q <= acc_d;
                end
            end

            assign stable_out[g] = acc_q;
        end
    endgenerate

endmodule : tic_debounce

/* File: tb/tic_monitor.sv */
// Port checker for the trigger input conditioning top.
// Assumes binding into tic_top; one sys_clk domain, sync reset.
`timescale 1ns/1ps
module tic_monitor #(
    parameter int MAIN_N  = 8,
    parameter int FRONT_N = 4
) (
    input wire logic                       sys_clk,
    input wire logic                       reset,
    input wire logic [MAIN_N-1:0]          main_input_pins,
    input wire logic [FRONT_N-1:0]         front_input_pins,
    input wire logic [tic_pkg::ADDR_W-1:0] avs_address,
    input wire logic                       avs_read,
    input wire logic                       avs_write,
    input wire logic [31:0]                avs_writedata,
    input wire logic [3:0]                 avs_byteenable,
    input wire logic [31:0]                avs_readdata,
    input wire logic                       avs_waitrequest,
    input wire logic                       ext_trigger_out,
    input wire logic                       stat_source_out
);
    // ========================================================================
    // Bus handshake
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    one_wait_a: assert property (s_take |=> s_answer)
        else $error("bus answer not after one wait state");
    no_spurious_a: assert property (!avs_waitrequest |->
        $past(avs_read) || $past(avs_write))
        else $error("answer without request");
    rdata_hold_a: assert property ($changed(avs_readdata) |->
        !avs_waitrequest)
        else $error("read data changed outside answer");
    // ========================================================================
    // Register contents
    main_upper_a: assert property (avs_read && avs_waitrequest &&
        avs_address == tic_pkg::OFS_MAIN_LEVELS |=>
        avs_readdata[31:MAIN_N] == '0)
        else $error("main level upper bits set");
    front_upper_a: assert property (avs_read && avs_waitrequest &&
        avs_address == tic_pkg::OFS_FRONT_LEVELS |=>
        avs_readdata[31:FRONT_N] == '0)
        else $error("front level upper bits set");
    unmapped_zero_a: assert property (avs_read && avs_waitrequest &&
        avs_address[1:0] != 2'h0 |=> avs_readdata == '0)
        else $error("unmapped read not zero");
    // ========================================================================
    // Trigger outputs
    ext_needs_stat_a: assert property (ext_trigger_out |->
        stat_source_out)
        else $error("trigger out without selected input");
    reset_clears_a: assert property (disable iff (1'b0) reset |=>
        avs_waitrequest && !ext_trigger_out && !stat_source_out)
        else $error("reset state wrong");
endmodule : tic_monitor

bind tic_top tic_monitor #(.MAIN_N(MAIN_N), .FRONT_N(FRONT_N)) tic_monitor_i (
    .sys_clk(sys_clk), .reset(reset), .main_input_pins(main_input_pins),
    .front_input_pins(front_input_pins), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_trigger_out(ext_trigger_out), .stat_source_out(stat_source_out));

/* File: tb/tic_src_model.sv */
// External trigger sources driving the main and front input pins.
// Assumes the bench sets wanted levels; pins follow on the next edge.
`timescale 1ns/1ps
module tic_src_model (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [7:0] want_main,
    input  wire logic [3:0] want_front,
    output logic      [7:0] main_pins,
    output logic      [3:0] front_pins
);
    // ========================================================================
    // Pin drivers
    always_ff @(posedge sys_clk) begin
        main_pins  <= reset ? 8'h00 : want_main;
        front_pins <= reset ? 4'h0 : want_front;
    end
endmodule : tic_src_model

/* File: tb/tb_top.sv */
// Bench for the trigger input conditioning top.
// Assumes tic_pkg, tic_top and tic_src_model are compiled first.
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk;
    logic        reset;
    logic [7:0]  want_main;
    logic [7:0]  main_pins;
    logic [3:0]  want_front;
    logic [3:0]  front_pins;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic        avs_waitrequest;
    logic        ext_trigger_out;
    logic        stat_source_out;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic [31:0] rd;
    logic [3:0]  be;
    int          errors;
    int          total_checks;
    int          hits;

    tic_src_model tic_src_model_i (.sys_clk(sys_clk), .reset(reset),
        .want_main(want_main), .want_front(want_front),
        .main_pins(main_pins), .front_pins(front_pins));
    tic_top tic_top_i (.sys_clk(sys_clk), .reset(reset),
        .main_input_pins(main_pins), .front_input_pins(front_pins),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .ext_trigger_out(ext_trigger_out),
        .stat_source_out(stat_source_out));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // ========================================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int i;
        i = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge sys_clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (i >= 50) begin
            errors++;
            finish_test();
        end
        @(posedge sys_clk);
    endtask : bus

    // Cycles until the statistics output reaches v, kept within lo..hi
    task automatic lat(input logic v, input int lo, input int hi);
        int i;
        i = 0;
        while (stat_source_out !== v && i < hi + 5) begin
            @(negedge sys_clk);
            i++;
        end
        check(32'(i >= lo && i <= hi), 32'h1);
        if (i >= hi + 5)
            finish_test();
        @(posedge sys_clk);
    endtask : lat

    // ========================================================================
    // Scenarios
    initial begin
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        be = 4'hF;
        want_main = 8'h00;
        want_front = 4'h0;
        errors = 0;
        total_checks = 0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, 4'h8, 32'h0); check(rd, 32'h139);
        bus(1'b0, 4'hC, 32'h0); check(rd, 32'h0);
        bus(1'b0, 4'h6, 32'h0); check(rd, 32'h0);
        want_main <= 8'h01;
        lat(1'b1, 251, 260);
        check(32'(ext_trigger_out), 32'h0);
        want_main <= 8'h25;
        want_front <= 4'hA;
        repeat (10) @(posedge sys_clk);
        bus(1'b1, 4'h0, 32'hFF);
        bus(1'b0, 4'h0, 32'h0); check(rd, 32'h25);
        bus(1'b0, 4'h4, 32'h0); check(rd, 32'hA);
        bus(1'b1, 4'h8, 32'h5);
        want_main <= 8'h00;
        want_front <= 4'h0;
        lat(1'b0, 5, 14);
        for (int k = 0; k < 12; k++) begin
            bus(1'b1, 4'hC, 32'h10 | 32'(k));
            if (k < 8) want_main <= 8'(1 << k);
            else want_front <= 4'(1 << (k - 8));
            lat(1'b1, 5, 14);
            check(32'(ext_trigger_out), 32'h1);
            want_main <= 8'h00;
            want_front <= 4'h0;
            lat(1'b0, 5, 14);
        end
        bus(1'b1, 4'h8, 32'd25);
        bus(1'b1, 4'hC, 32'h10);
        want_main <= 8'h01;
        repeat (12) @(posedge sys_clk);
        want_main <= 8'h00;
        hits = 0;
        repeat (40) begin
            @(negedge sys_clk);
            if (stat_source_out !== 1'b0) hits++;
        end
        check(32'(hits), 32'h0);
        @(posedge sys_clk);
        want_main <= 8'h01;
        repeat (10) @(posedge sys_clk);
        want_main <= 8'h00;
        repeat (2) @(posedge sys_clk);
        want_main <= 8'h01;
        lat(1'b1, 21, 30);
        bus(1'b1, 4'hC, 32'h120);
        lat(1'b0, 0, 8);
        check(32'(ext_trigger_out), 32'h0);
        bus(1'b1, 4'hC, 32'h13C);
        bus(1'b0, 4'hC, 32'h0); check(rd, 32'h120);
        bus(1'b1, 4'hC, 32'h0);
        repeat (4) @(posedge sys_clk);
        want_main <= 8'h00;
        lat(1'b0, 21, 30);
        want_main <= 8'h01;
        lat(1'b1, 21, 30);
        check(32'(ext_trigger_out), 32'h0);
        be <= 4'h1;
        bus(1'b1, 4'h8, 32'hFFFF_FF07);
        be <= 4'hF;
        bus(1'b0, 4'h8, 32'h0); check(rd, 32'h7);
        finish_test();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        finish_test();
    end
endmodule : tb_top
